// ### core/gear_pkg.sv
// Purpose: Constants and types shared by both ends of the gear link
// Assumes: 50 MHz core_clk, synchronous active-high rst
// Notes: How it works list below
//
// How it works
// - Resolution is 1000 times numerator over denominator
// - Accept resolution 100 to 10000, default 1000
// - Out-of-range resolution raises gear info flag
// - Restart or configure escalates info to alarm
// - Source select: 0 sensor values, 1 manual
// - Gear denominator and numerator, both default 1
// - Source select change waits for power cycle
// - Preset zero: clear position to zero on resolution change
// - Nonzero preset: host repeats preset after change
// - Phase A/B pulses track motor motion
// - Pulse resolution latched at power-on, follows changes
// - Factory state prefers sensor fixed values
// - Any parameter write switches all to driver
// - Bulk copy skips manual-written parameters
// - Host restarts power after bulk copy
// - Report active, driver and sensor values
// - Keep power five seconds after write; else alarm
package gear_pkg;
	// ==========================================================
	// Numeric constants
	localparam logic [15:0] base_res = 16'h03e8;
	localparam logic [31:0] res_min = 32'h0000_0064;
	localparam logic [31:0] res_max = 32'h0000_2710;
	localparam logic [15:0] res_default = 16'h03e8;
	localparam logic [15:0] gear_default = 16'h0001;
	localparam logic [15:0] preset_default = 16'h0000;
	localparam logic sel_sensor = 1'b0;
	localparam logic sel_manual = 1'b1;
	localparam int clk_mhz = 50;
	localparam int nv_hold_s = 5;
	localparam longint nv_hold_cyc = longint'(nv_hold_s) * clk_mhz * 1000000;
	// ==========================================================
	// Parameter identifiers on the link
	localparam logic [2:0] pid_gear_den = 3'h0;
	localparam logic [2:0] pid_gear_num = 3'h1;
	localparam logic [2:0] pid_mech_sel = 3'h2;
	localparam logic [2:0] pid_preset = 3'h3;
	// Read view selector
	localparam logic [1:0] view_active = 2'h0;
	localparam logic [1:0] view_driver = 2'h1;
	localparam logic [1:0] view_sensor = 2'h2;
	// ==========================================================
	// Commands
	typedef enum logic [2:0] {
		cmd_none, cmd_write, cmd_read, cmd_configure,
		cmd_copy_sensor, cmd_nv_save, cmd_preset
	} cmd_t;
	// ==========================================================
	// APB register offsets of the host end
	localparam logic [7:0] reg_ctrl = 8'h00;
	localparam logic [7:0] reg_wdata = 8'h04;
	localparam logic [7:0] reg_status = 8'h08;
	localparam logic [7:0] reg_rdata = 8'h0c;
	localparam logic [7:0] reg_count = 8'h10;
	// Ctrl fields
	localparam int ctrl_cmd_lsb = 0;
	localparam int ctrl_pid_lsb = 4;
	localparam int ctrl_view_lsb = 8;
	localparam int ctrl_go_bit = 31;
	// Status fields
	localparam int st_busy_bit = 0;
	localparam int st_info_bit = 1;
	localparam int st_alarm_bit = 2;
	localparam int st_mem_bit = 3;

	function automatic logic [31:0] calc_res(input logic [15:0] num,
		input logic [15:0] den);
		logic [31:0] p;
		p = 32'(num) * 32'(base_res);
		calc_res = (den == 16'h0000) ? 32'h0000_0000 : p / 32'(den);
	endfunction : calc_res

	function automatic logic res_ok(input logic [31:0] r);
		res_ok = (r >= res_min) && (r <= res_max);
	endfunction : res_ok
endpackage : gear_pkg

// ### core/gear_link_if.sv
// Purpose: Command and pulse link between host and servo parameter logic
// Assumes: Single core_clk domain
// Notes: Request valid held until ack pulse
`timescale 1ns/1ps
`default_nettype none
interface gear_link_if import gear_pkg::*; ();
	logic req;
	cmd_t cmd;
	logic [2:0] pid;
	logic [1:0] view;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;
	logic power_cycle;
	logic info_gear;
	logic alarm_gear;
	logic alarm_mem;
	logic phase_a_position_output;
	logic phase_b_position_output;
	modport drv (input req, cmd, pid, view, wdata, power_cycle,
		output ack, rdata, info_gear, alarm_gear, alarm_mem,
		phase_a_position_output, phase_b_position_output);
	modport hst (output req, cmd, pid, view, wdata, power_cycle,
		input ack, rdata, info_gear, alarm_gear, alarm_mem,
		phase_a_position_output, phase_b_position_output);
endinterface : gear_link_if
`default_nettype wire

// ### core/gear_drive.sv
// Purpose: Servo-side gear parameters, resolution check and A/B pulses
// Assumes: Link from same clock; motor steps from outside, synchronised
// Notes: power_cycle models control power restart
`timescale 1ns/1ps
`default_nettype none
module gear_drive import gear_pkg::*; #(
	parameter longint nv_hold = nv_hold_cyc,
	parameter logic [15:0] sensor_den = 16'h000a,
	parameter logic [15:0] sensor_num = 16'h000c,
	parameter logic sensor_sel = 1'b0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Link
	gear_link_if.drv link,
	// Motor motion and power
	input wire logic motor_step,
	input wire logic motor_dir,
	input wire logic power_fail,
	output logic [31:0] position,
	output logic [31:0] resolution
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [15:0] drv_den, drv_num, drv_preset;
		logic drv_sel, sel_act, use_drv;
		logic [15:0] man_mask;
		logic info, alarm, mem_alarm;
		logic [31:0] res, pulse_res, pos;
		logic [15:0] acc;
		logic [1:0] quad;
		logic nv_busy;
		logic [63:0] nv_cnt;
		logic ack;
		logic [15:0] rdata;
		logic s1, s2, s3, d1, d2, p1, p2;
	} st_t;
	st_t s_q, s_d;
	logic [15:0] act_den, act_num;
	logic [31:0] new_res;
	logic step_rise;

	always_comb begin
		// Sensor fixed values in factory state, driver after a write
		act_den = s_q.use_drv ? s_q.drv_den : sensor_den;
		act_num = s_q.use_drv ? s_q.drv_num : sensor_num;
		step_rise = s_q.s2 && !s_q.s3;
		new_res = calc_res(act_num, act_den);
	end

	always_comb begin
		s_d = s_q;
		s_d.s1 = motor_step;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		s_d.d1 = motor_dir;
		s_d.d2 = s_q.d1;
		s_d.p1 = power_fail;
		s_d.p2 = s_q.p1;
		s_d.ack = 1'b0;
		// Range check on every gear change, flag held until valid
		if (res_ok(new_res)) begin
			s_d.info = 1'b0;
			if (new_res != s_q.res) begin
				s_d.res = new_res;
				s_d.pulse_res = new_res;
				if (s_q.drv_preset == preset_default)
					s_d.pos = 32'h0000_0000;
			end
		end else begin
			s_d.info = 1'b1;
		end
		// Non-volatile hold window
		if (s_q.nv_busy) begin
			if (s_q.p2)
				s_d.mem_alarm = 1'b1;
			if (s_q.nv_cnt == 64'(nv_hold))
				s_d.nv_busy = 1'b0;
			else
				s_d.nv_cnt = s_q.nv_cnt + 64'h1;
		end
		// Motion: quadrature phase and counted position
		if (step_rise) begin
			s_d.quad = s_q.d2 ? s_q.quad + 2'h1 : s_q.quad - 2'h1;
			s_d.pos = s_q.d2 ? s_q.pos + 32'h1 : s_q.pos - 32'h1;
		end
		if (link.power_cycle) begin
			s_d.sel_act = s_q.drv_sel;
			s_d.pulse_res = s_q.res;
			if (s_q.info)
				s_d.alarm = 1'b1;
		end else if (link.req && !s_q.ack) begin
			s_d.ack = 1'b1;
			case (link.cmd)
				cmd_write: begin
					s_d.use_drv = 1'b1;
					if (s_q.sel_act == sel_manual)
						s_d.man_mask[link.pid] = 1'b1;
					case (link.pid)
						pid_gear_den: s_d.drv_den = link.wdata;
						pid_gear_num: s_d.drv_num = link.wdata;
						pid_mech_sel: s_d.drv_sel = link.wdata[0];
						pid_preset: s_d.drv_preset = link.wdata;
						default: ;
					endcase
				end
				cmd_configure: begin
					if (s_q.info)
						s_d.alarm = 1'b1;
				end
				cmd_copy_sensor: begin
					if (!s_q.man_mask[pid_gear_den])
						s_d.drv_den = sensor_den;
					if (!s_q.man_mask[pid_gear_num])
						s_d.drv_num = sensor_num;
					if (!s_q.man_mask[pid_mech_sel])
						s_d.drv_sel = sensor_sel;
				end
				cmd_nv_save: begin
					s_d.nv_busy = 1'b1;
					s_d.nv_cnt = 64'h0;
				end
				cmd_preset: s_d.pos = 32'(s_q.drv_preset);
				cmd_read: begin
					// Three views for gear den, gear num and source select; preset reads the driver value
					case ({link.view, link.pid})
						{view_active, pid_gear_den}: s_d.rdata = act_den;
						{view_active, pid_gear_num}: s_d.rdata = act_num;
						{view_active, pid_mech_sel}:
							s_d.rdata = 16'(s_q.sel_act);
						{view_driver, pid_gear_den}: s_d.rdata = s_q.drv_den;
						{view_driver, pid_gear_num}: s_d.rdata = s_q.drv_num;
						{view_driver, pid_mech_sel}:
							s_d.rdata = 16'(s_q.drv_sel);
						{view_sensor, pid_gear_den}: s_d.rdata = sensor_den;
						{view_sensor, pid_gear_num}: s_d.rdata = sensor_num;
						{view_sensor, pid_mech_sel}:
							s_d.rdata = 16'(sensor_sel);
						default: s_d.rdata = s_q.drv_preset;
					endcase
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.drv_den <= gear_default;
			s_q.drv_num <= gear_default;
			s_q.drv_sel <= sel_sensor;
			s_q.sel_act <= sel_sensor;
			s_q.res <= 32'(res_default);
			s_q.pulse_res <= 32'(res_default);
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign link.ack = s_q.ack;
	assign link.rdata = s_q.rdata;
	assign link.info_gear = s_q.info;
	assign link.alarm_gear = s_q.alarm;
	assign link.alarm_mem = s_q.mem_alarm;
	assign link.phase_a_position_output = s_q.quad[1];
	assign link.phase_b_position_output = s_q.quad[1] ^ s_q.quad[0];
	assign position = s_q.pos;
	assign resolution = s_q.pulse_res;
endmodule : gear_drive
`default_nettype wire

// ### core/gear_host.sv
// Purpose: Host end: APB-driven command issue and A/B pulse counter
// Assumes: Link from same clock; APB slave on core_clk
// Notes: Pulse inputs are synchronised before counting
`timescale 1ns/1ps
`default_nettype none
module gear_host import gear_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power control
	input wire logic power_restart,
	// Link
	gear_link_if.hst link
);
	typedef enum logic [1:0] {h_idle, h_wait} hstate_t;
	typedef struct packed {
		hstate_t fsm;
		logic [31:0] ctrl, wdata, rdata, cnt, prdata;
		logic pslverr;
		logic a1, a2, a3, b1, b2, b3;
	} hs_t;
	hs_t h_q, h_d;
	logic acc;

	// Quadrature phase index rebuilt from A and B
	function automatic logic [1:0] qpos(input logic a, input logic b);
		qpos = {a, a ^ b};
	endfunction : qpos

	always_comb begin
		acc = psel && penable;
		h_d = h_q;
		h_d.a1 = link.phase_a_position_output;
		h_d.a2 = h_q.a1;
		h_d.a3 = h_q.a2;
		h_d.b1 = link.phase_b_position_output;
		h_d.b2 = h_q.b1;
		h_d.b3 = h_q.b2;
		h_d.pslverr = 1'b0;
		// One count per phase step, so the count follows position
		if (qpos(h_q.a2, h_q.b2) == qpos(h_q.a3, h_q.b3) + 2'h1)
			h_d.cnt = h_q.cnt + 32'h1;
		else if (qpos(h_q.a2, h_q.b2) == qpos(h_q.a3, h_q.b3) - 2'h1)
			h_d.cnt = h_q.cnt - 32'h1;
		case (h_q.fsm)
			h_idle: begin
				if (h_q.ctrl[ctrl_go_bit])
					h_d.fsm = h_wait;
			end
			h_wait: begin
				if (link.ack) begin
					h_d.rdata = 32'(link.rdata);
					h_d.ctrl[ctrl_go_bit] = 1'b0;
					h_d.fsm = h_idle;
				end
			end
			default: h_d.fsm = h_idle;
		endcase
		if (psel && !penable) begin
			case (paddr)
				reg_ctrl: h_d.prdata = h_q.ctrl;
				reg_wdata: h_d.prdata = h_q.wdata;
				reg_status: h_d.prdata = {28'h0, link.alarm_mem,
					link.alarm_gear, link.info_gear, h_q.fsm == h_wait};
				reg_rdata: h_d.prdata = h_q.rdata;
				reg_count: h_d.prdata = h_q.cnt;
				default: h_d.prdata = 32'h0;
			endcase
		end
		if (acc) begin
			h_d.pslverr = !(paddr == reg_ctrl || paddr == reg_wdata ||
				paddr == reg_status || paddr == reg_rdata ||
				paddr == reg_count);
			if (pwrite && paddr == reg_ctrl && h_q.fsm == h_idle)
				h_d.ctrl = pwdata;
			if (pwrite && paddr == reg_wdata)
				h_d.wdata = pwdata;
			if (pwrite && paddr == reg_count)
				h_d.cnt = pwdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			h_q <= '0;
		else if (clk_en)
			h_q <= h_d;
	end

	assign pready = 1'b1;
	assign prdata = h_q.prdata;
	assign pslverr = acc && !(paddr == reg_ctrl || paddr == reg_wdata ||
		paddr == reg_status || paddr == reg_rdata || paddr == reg_count);
	// Host restarts power after copy or source change
	assign link.power_cycle = power_restart;
	assign link.req = (h_q.fsm == h_wait);
	assign link.cmd = cmd_t'(h_q.ctrl[ctrl_cmd_lsb +: 3]);
	assign link.pid = h_q.ctrl[ctrl_pid_lsb +: 3];
	assign link.view = h_q.ctrl[ctrl_view_lsb +: 2];
	assign link.wdata = h_q.wdata[15:0];
endmodule : gear_host
`default_nettype wire

// ### tb/gear_link_asserts.sv
// Purpose: Checks the link between host and drive
// Assumes: One clock, rst synchronous active high
// Notes: Shadows the gear values written over the link
`timescale 1ns/1ps
`default_nettype none
module gear_link_asserts import gear_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Link
	input wire logic req,
	input wire cmd_t cmd,
	input wire logic [2:0] pid,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic power_cycle,
	input wire logic info_gear,
	input wire logic alarm_gear,
	input wire logic phase_a_position_output,
	input wire logic phase_b_position_output
);
	// ====================
	// Gear shadow
	typedef struct packed {
		logic [15:0] num;
		logic [15:0] den;
	} shadow_t;
	shadow_t s_q, s_d;
	logic [31:0] res;
	logic wr, bad;
	assign wr = ack && cmd == cmd_write;
	assign res = 32'(s_q.num) * 32'(base_res) / 32'(s_q.den);
	assign bad = res < res_min || res > res_max;
	always_comb begin
		s_d = s_q;
		if (wr && pid == pid_gear_num)
			s_d.num = wdata;
		if (wr && pid == pid_gear_den)
			s_d.den = wdata;
	end
	always_ff @(posedge core_clk) begin
		if (rst)
			s_q <= {gear_default, gear_default};
		else
			s_q <= s_d;
	end
	// ====================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_ack_pulse: assert property (ack |=> !ack)
		else $error("ack too long");
	a_req_answered: assert property (req && !ack && !power_cycle
		|-> ##[1:3] (ack || power_cycle)) else $error("no ack");
	a_ack_cause: assert property (ack |-> $past(req))
		else $error("ack without req");
	a_gear_info: assert property (wr && pid < 3'h2
		|=> ##2 info_gear == bad) else $error("info flag wrong");
	a_info_hold: assert property ($fell(info_gear)
		&& !$past(power_cycle) |-> !bad) else $error("info dropped");
	a_alarm_cfg: assert property (info_gear && ack
		&& cmd == cmd_configure |-> ##[0:3] alarm_gear)
		else $error("no gear alarm");
	a_alarm_cause: assert property ($rose(alarm_gear)
		|-> $past(info_gear) || info_gear) else $error("stray alarm");
	a_quad_gray: assert property (!($changed(phase_a_position_output)
		&& $changed(phase_b_position_output))) else $error("A/B jump");
	c_info: cover property ($rose(info_gear));
	c_alarm: cover property ($rose(alarm_gear));
	c_pulse: cover property ($changed(phase_a_position_output));
endmodule : gear_link_asserts
`default_nettype wire

// ### tb/test_electronic_gear_resolution.sv
// Purpose: Self-checking bench for the host and drive pair
// Assumes: 50 MHz core_clk, rst held 3 cycles
// Notes: Reads are checked by a monitor against a queue
`timescale 1ns/1ps
`default_nettype none
module test_electronic_gear_resolution import gear_pkg::*;;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, position, resolution, rd;
	logic pready, pslverr, err, poll = 1'b0;
	logic motor_step = 1'b0, motor_dir = 1'b1, power_fail = 1'b0;
	logic power_restart = 1'b0;
	logic [63:0] exp_q[$];
	int err_count = 0, samples_checked = 0;
	gear_link_if link();
	always #10 core_clk = ~core_clk;
	gear_drive #(.nv_hold(16)) u_gear_drive (.core_clk(core_clk),
		.rst(rst), .clk_en(clk_en), .link(link), .motor_step(motor_step),
		.motor_dir(motor_dir), .power_fail(power_fail),
		.position(position), .resolution(resolution));
	gear_host u_gear_host (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_restart(power_restart), .link(link));
	gear_link_asserts u_gear_link_asserts (.core_clk(core_clk), .rst(rst),
		.req(link.req), .cmd(link.cmd), .pid(link.pid), .wdata(link.wdata),
		.ack(link.ack), .power_cycle(link.power_cycle),
		.info_gear(link.info_gear), .alarm_gear(link.alarm_gear),
		.phase_a_position_output(link.phase_a_position_output),
		.phase_b_position_output(link.phase_b_position_output));
	// ====================
	// Tasks
	task automatic check(input string w, input logic [31:0] s,
		input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", w, e, s);
		end
	endtask : check
	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic expect_rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		exp_q.push_back({m, e});
		apb(1'b0, a, 32'h0);
	endtask : expect_rd
	task automatic run(input cmd_t c, input logic [2:0] p,
		input logic [1:0] v, input logic [15:0] d);
		int n;
		n = 0;
		apb(1'b1, reg_wdata, {16'h0, d});
		apb(1'b1, reg_ctrl, {1'b1, 21'h0, v, 1'b0, p, 1'b0, c});
		poll <= 1'b1;
		do begin
			apb(1'b0, reg_status, 32'h0);
			n++;
		end while (rd[st_busy_bit] !== 1'b0 && n < 20);
		poll <= 1'b0;
		if (n >= 20)
			err_count++;
	endtask : run
	task automatic get(input logic [2:0] p, input logic [1:0] v,
		input logic [15:0] e);
		run(cmd_read, p, v, 16'h0);
		expect_rd(reg_rdata, 32'hffff, {16'h0, e});
	endtask : get
	task automatic st(input logic [2:0] e);
		expect_rd(reg_status, 32'he, {28'h0, e, 1'b0});
	endtask : st
	task automatic step(input logic d);
		motor_dir <= d;
		motor_step <= 1'b1;
		repeat (4) @(posedge core_clk);
		motor_step <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : step
	// ====================
	// Monitor
	always @(posedge core_clk) begin : mon
		logic [63:0] x;
		if (psel && penable && pready === 1'b1 && !pwrite && !poll
			&& exp_q.size() > 0) begin
			x = exp_q.pop_front();
			check("read", prdata & x[63:32], x[31:0]);
		end
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		stop_test();
	end
	// ====================
	// Main sequence
	initial begin
		logic [31:0] t;
		logic [31:0] tab[6] = '{32'h000c_000a, 32'h0024_000a,
			32'h0001_000a, 32'h000a_0001, 32'h0001_000b, 32'h000b_0001};
		logic bad;
		int r;
		void'($urandom(76));
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		st(3'b000);
		get(pid_gear_num, view_sensor, 16'h000c);
		get(pid_gear_num, view_driver, gear_default);
		get(pid_gear_den, view_active, 16'h000a);
		get(pid_mech_sel, view_active, 16'h0000);
		expect_rd(8'h14, 32'hffffffff, 32'h0);
		check("slverr", {31'h0, err}, 32'h1);
		run(cmd_write, pid_mech_sel, view_active, 16'h0001);
		power_restart <= 1'b1;
		repeat (4) @(posedge core_clk);
		power_restart <= 1'b0;
		repeat (4) @(posedge core_clk);
		get(pid_mech_sel, view_active, 16'h0001);
		for (int i = 0; i < 9; i++) begin
			t = (i < 6) ? tab[i] : {16'($urandom_range(40, 1)),
				16'($urandom_range(40, 1))};
			if (i == 8)
				t = 32'h000c_000a;
			run(cmd_write, pid_gear_den, view_active, t[15:0]);
			run(cmd_write, pid_gear_num, view_active, t[31:16]);
			r = int'(t[31:16]) * 1000 / int'(t[15:0]);
			bad = r < 100 || r > 10000;
			st({2'b00, bad});
			if (!bad)
				check("res", resolution, 32'(r));
		end
		get(pid_gear_num, view_active, 16'h000c);
		apb(1'b1, reg_count, 32'h0);
		repeat (3) step(1'b1);
		expect_rd(reg_count, 32'hffffffff, 32'h3);
		repeat (3) step(1'b0);
		repeat (8) @(posedge core_clk);
		expect_rd(reg_count, 32'hffffffff, 32'h0);
		repeat (2) step(1'b1);
		run(cmd_write, pid_gear_num, view_active, 16'h0024);
		check("position", position, 32'h0);
		clk_en <= 1'b0;
		step(1'b1);
		clk_en <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("frozen", position, 32'h0);
		run(cmd_copy_sensor, pid_gear_den, view_active, 16'h0);
		get(pid_gear_num, view_driver, 16'h0024);
		run(cmd_write, pid_preset, view_active, 16'h0005);
		run(cmd_preset, pid_preset, view_active, 16'h0);
		check("preset", position, 32'h5);
		run(cmd_write, pid_gear_den, view_active, 16'h000b);
		check("kept", position, 32'h5);
		run(cmd_write, pid_gear_num, view_active, 16'h0001);
		st(3'b001);
		run(cmd_configure, pid_gear_den, view_active, 16'h0);
		st(3'b011);
		apb(1'b1, reg_ctrl, {1'b1, 28'h0, cmd_nv_save});
		power_fail <= 1'b1;
		repeat (3) @(posedge core_clk);
		power_fail <= 1'b0;
		repeat (20) @(posedge core_clk);
		expect_rd(reg_status, 32'h8, 32'h8);
		stop_test();
	end
endmodule : test_electronic_gear_resolution
`default_nettype wire
